// file: inc/seq_pkg.sv
// Shared constants, command codes and carriers of the output and list sequencer
// How it works
// - Output-off command keeps voltage and current setpoints, then drives both outputs zero.
// - Output-on command reapplies the kept setpoints; setpoint queries report them.
// - Local after reset with output on; entering remote turns output off.
// - Output-state query answers 0 when disabled, 1 when enabled.
// - Regulation mode is held by command; query answers 0 voltage, 1 current.
// - Voltage mode flags current-limit hits; current mode flags voltage-limit hits.
// - Separate trigger regulation mode, entered on trigger, saved and recalled, queryable.
// - List clear zeroes pointers, sets upward order, default ordering, repeat total 1.
// - Repeat total 0 to 255 sets list executions; query returns it.
// - Running list stops on fixed/transient programming or a voltage/current regulation mode command; trigger mode commands leave it running.
// - First pass runs every step; later passes omit the first nn steps.
// - List clear also zeroes the leading-step omit count.
// - Leading-step omit acts only in upward order, never downward.
// - Current appends fill consecutive locations from the fill pointer, at most 1002.
// - With voltage entries present, current append, readback or count posts -221.
// - Current readback returns one value, at offset 0 to 15 from the readback start pointer.
// - Current fill pointer starts at zero after clear, advances per value entered.
// - Step hold is 0.5 ms to 16383.5 ms; a lone location-zero hold applies everywhere.
// - List runs first to last upward or last to first downward.
// - After all repetitions the list stops, holding the last executed step.
package seq_pkg;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam int TABLE_DEPTH = 1002;
  localparam int READBACK_MAX = 16;
  localparam int CNT_W = 8;
  localparam int HOLD_W = 15;
  localparam int UNIT_CNT_W = 16;
  localparam int ADDR_W = 12;
  localparam logic [CNT_W-1:0] REPEAT_CLEAR = 8'h01;
  localparam logic [CNT_W-1:0] OMIT_CLEAR = 8'h00;
  localparam logic [HOLD_W-1:0] HOLD_MIN_UNITS = 15'h0001;
  localparam int CLK_PERIOD_NS = 25;
  localparam int HOLD_UNIT_NS = 500000;
  localparam int HOLD_UNIT_CYC = HOLD_UNIT_NS / CLK_PERIOD_NS;
  // Settings conflict, -221 in 16-bit two's complement
  localparam logic [15:0] ERR_SETTINGS_CONFLICT = 16'hFF23;
  localparam logic [ADDR_W-1:0] OFS_CMD = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_ARG = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_ERROR = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_FILL = 12'h014;
  localparam int ST_OUT_ON = 0;
  localparam int ST_REG_MODE = 1;
  localparam int ST_TRIG_MODE = 2;
  localparam int ST_RUNNING = 3;
  localparam int ST_REMOTE = 4;
  localparam int ST_DIR_DOWN = 5;
  localparam int ST_ORDER = 6;
  localparam int ST_LIMIT_ERR = 7;
  localparam int ST_CONFLICT = 8;
  localparam int ST_RESULT_NEW = 9;
  localparam int FILL_V_LSB = 16;
  typedef enum logic [7:0] {
    OP_NONE = 8'h00, OP_OUT_OFF = 8'h01, OP_OUT_ON = 8'h02,
    OP_REMOTE = 8'h03, OP_LOCAL = 8'h04, OP_SET_VOLT = 8'h05,
    OP_SET_CURR = 8'h06, OP_REG_VOLT = 8'h07, OP_REG_CURR = 8'h08,
    OP_TRIG_VOLT = 8'h09, OP_TRIG_CURR = 8'h0A, OP_TRIGGER = 8'h0B,
    OP_SETUP_SAVE = 8'h0C, OP_SETUP_RECALL = 8'h0D, OP_LIST_CLEAR = 8'h0E,
    OP_SET_REPEAT = 8'h0F, OP_SET_OMIT = 8'h10, OP_CURR_APPEND = 8'h11,
    OP_VOLT_APPEND = 8'h12, OP_HOLD_APPEND = 8'h13, OP_SET_DIR = 8'h14,
    OP_SET_ORDER = 8'h15, OP_SET_QPTR = 8'h16, OP_RUN_LIST = 8'h17,
    OP_STYLE_FIXED = 8'h18, OP_STYLE_TRAN = 8'h19, OP_Q_OUT = 8'h20,
    OP_Q_REG = 8'h21, OP_Q_TRIG = 8'h22, OP_Q_REPEAT = 8'h23,
    OP_Q_OMIT = 8'h24, OP_Q_READBACK = 8'h25, OP_Q_FILL = 8'h26,
    OP_Q_VOLT = 8'h27, OP_Q_CURR = 8'h28
  } op_t;
  typedef enum logic [2:0] {
    RUN_IDLE = 3'b001,
    RUN_LOAD = 3'b010,
    RUN_HOLD = 3'b100
  } run_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } apb_rsp_t;
  typedef struct packed {
    logic [DATA_W-1:0] volt;
    logic [DATA_W-1:0] curr;
  } prog_out_t;
endpackage

// file: design/pin_sync.sv
// Three-stage synchroniser with agreement filter for pin levels
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_st_t;
  sync_st_t st_r;
  sync_st_t st_nxt;
  if (W < 1)
  begin : g_chk
    $error("pin_sync width must be positive");
  end
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
      begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
  assign level = st_r.lvl;
endmodule
`default_nettype wire

// file: design/step_table.sv
// Flip-flop step table with one write port and two read ports
`timescale 1ns/10ps
`default_nettype none
module step_table #(
  parameter int W = 32,
  parameter int DEPTH = 1002,
  parameter int IW = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [IW-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic [IW-1:0] rd_a_idx,
  output logic [W-1:0] rd_a_data,
  input wire logic [IW-1:0] rd_b_idx,
  output logic [W-1:0] rd_b_data
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
  } tbl_st_t;
  tbl_st_t st_r;
  tbl_st_t st_nxt;
  if (DEPTH < 1 || DEPTH > (1 << IW) || W < 1)
  begin : g_chk
    $error("step_table depth does not fit its index width");
  end
  always_comb
  begin
    st_nxt = st_r;
    if (wr_en && wr_idx < IW'(DEPTH))
    begin
      st_nxt.mem[wr_idx] = wr_data;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
  assign rd_a_data = (rd_a_idx < IW'(DEPTH)) ? st_r.mem[rd_a_idx] : '0;
  assign rd_b_data = (rd_b_idx < IW'(DEPTH)) ? st_r.mem[rd_b_idx] : '0;
endmodule
`default_nettype wire

// file: design/output_and_list_sequencer.sv
// Output switch, regulation modes and list processor behind an APB slave
`timescale 1ns/10ps
`default_nettype none
module output_and_list_sequencer #(
  parameter int HOLD_UNIT_CYC = seq_pkg::HOLD_UNIT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire seq_pkg::apb_req_t apb_in,
  output seq_pkg::apb_rsp_t apb_out,
  input wire logic cur_limit_pin,
  input wire logic volt_limit_pin,
  output seq_pkg::prog_out_t prog,
  output logic out_enabled,
  output logic panel_active,
  output logic regulation_current,
  output logic list_running
);
  typedef struct packed {
    logic remote;
    logic out_on;
    logic reg_mode;
    logic trig_mode;
    logic saved_trig;
    logic dir_down;
    logic order_custom;
    logic [seq_pkg::DATA_W-1:0] vset;
    logic [seq_pkg::DATA_W-1:0] iset;
    seq_pkg::prog_out_t prog;
    logic [seq_pkg::DATA_W-1:0] arg;
    logic [seq_pkg::DATA_W-1:0] result;
    logic result_new;
    logic [15:0] err_code;
    logic conflict;
    logic limit_err;
    logic [seq_pkg::IDX_W-1:0] cfill;
    logic [seq_pkg::IDX_W-1:0] vfill;
    logic [seq_pkg::IDX_W-1:0] hfill;
    logic [seq_pkg::IDX_W-1:0] qptr;
    logic [seq_pkg::CNT_W-1:0] repeat_total;
    logic [seq_pkg::CNT_W-1:0] lead_step_omit;
    seq_pkg::run_t run;
    logic [seq_pkg::IDX_W-1:0] idx;
    logic [seq_pkg::IDX_W-1:0] len;
    logic [seq_pkg::CNT_W-1:0] pass;
    logic [seq_pkg::UNIT_CNT_W-1:0] unit_cnt;
    logic [seq_pkg::HOLD_W-1:0] hold_left;
  } seq_st_t;

  localparam logic [seq_pkg::IDX_W-1:0] DEPTH_IDX = seq_pkg::IDX_W'(seq_pkg::TABLE_DEPTH);
  localparam logic [seq_pkg::UNIT_CNT_W-1:0] UNIT_LAST =
    seq_pkg::UNIT_CNT_W'(HOLD_UNIT_CYC - 1);

  if (HOLD_UNIT_CYC < 1 || HOLD_UNIT_CYC > (1 << seq_pkg::UNIT_CNT_W))
  begin : g_chk
    $error("HOLD_UNIT_CYC out of range");
  end

  seq_st_t st_r;
  seq_st_t st_nxt;
  logic [1:0] limits;
  logic tbl_we;
  logic [seq_pkg::IDX_W-1:0] tbl_widx;
  logic [seq_pkg::DATA_W-1:0] step_val;
  logic [seq_pkg::IDX_W-1:0] rb_idx;
  logic [seq_pkg::DATA_W-1:0] rb_val;
  logic hold_we;
  logic [seq_pkg::IDX_W-1:0] hold_ridx;
  logic [seq_pkg::HOLD_W-1:0] hold_val;
  logic bus_wr;
  logic bus_rd;
  logic go;
  seq_pkg::op_t op;
  logic step_last;
  logic [seq_pkg::HOLD_W-1:0] hold_units;

  // Wrap index arithmetic back to the index width
  function automatic logic [seq_pkg::IDX_W-1:0] idx_add(
    input logic [seq_pkg::IDX_W-1:0] a,
    input logic [seq_pkg::IDX_W-1:0] b
  );
    idx_add = seq_pkg::IDX_W'(a + b);
  endfunction

  pin_sync #(
    .W(2)
  ) u_limit_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({volt_limit_pin, cur_limit_pin}),
    .level(limits)
  );

  step_table #(
    .W(seq_pkg::DATA_W),
    .DEPTH(seq_pkg::TABLE_DEPTH),
    .IW(seq_pkg::IDX_W)
  ) u_main_table (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(tbl_we),
    .wr_idx(tbl_widx),
    .wr_data(st_r.arg),
    .rd_a_idx(st_r.idx),
    .rd_a_data(step_val),
    .rd_b_idx(rb_idx),
    .rd_b_data(rb_val)
  );

  step_table #(
    .W(seq_pkg::HOLD_W),
    .DEPTH(seq_pkg::TABLE_DEPTH),
    .IW(seq_pkg::IDX_W)
  ) u_hold_table (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(hold_we),
    .wr_idx(st_r.hfill),
    .wr_data(st_r.arg[seq_pkg::HOLD_W-1:0]),
    .rd_a_idx(hold_ridx),
    .rd_a_data(hold_val),
    .rd_b_idx('0),
    .rd_b_data()
  );

  assign bus_wr = apb_in.psel && apb_in.penable && apb_in.pwrite;
  assign bus_rd = apb_in.psel && apb_in.penable && !apb_in.pwrite;
  assign go = bus_wr && apb_in.paddr == seq_pkg::OFS_CMD;
  assign op = seq_pkg::op_t'(apb_in.pwdata[7:0]);
  assign rb_idx = idx_add(st_r.qptr, seq_pkg::IDX_W'(st_r.arg[3:0]));
  // A lone location-zero hold serves every step
  assign hold_ridx = (st_r.hfill == seq_pkg::IDX_W'(1)) ? '0 : st_r.idx;
  assign hold_units = (st_r.hfill == '0 || hold_val == '0) ?
    seq_pkg::HOLD_MIN_UNITS : hold_val;
  assign step_last = st_r.dir_down ? (st_r.idx == '0) :
    (st_r.idx == idx_add(st_r.len, '1));

  always_comb
  begin
    st_nxt = st_r;
    tbl_we = 1'b0;
    tbl_widx = st_r.cfill;
    hold_we = 1'b0;
    if (bus_wr && apb_in.paddr == seq_pkg::OFS_ARG)
    begin
      st_nxt.arg = apb_in.pwdata;
    end
    if (bus_wr && apb_in.paddr == seq_pkg::OFS_ERROR)
    begin
      st_nxt.conflict = 1'b0;
      st_nxt.limit_err = 1'b0;
    end
    if (bus_rd && apb_in.paddr == seq_pkg::OFS_RESULT)
    begin
      st_nxt.result_new = 1'b0;
    end
    if ((!st_r.reg_mode && limits[0]) || (st_r.reg_mode && limits[1]))
    begin
      st_nxt.limit_err = 1'b1;
    end
    case (st_r.run)
      seq_pkg::RUN_IDLE:
      begin
        st_nxt.run = seq_pkg::RUN_IDLE;
      end
      seq_pkg::RUN_LOAD:
      begin
        if (st_r.reg_mode)
        begin
          st_nxt.iset = step_val;
        end
        else
        begin
          st_nxt.vset = step_val;
        end
        st_nxt.hold_left = hold_units;
        st_nxt.unit_cnt = '0;
        st_nxt.run = seq_pkg::RUN_HOLD;
      end
      seq_pkg::RUN_HOLD:
      begin
        if (st_r.unit_cnt != UNIT_LAST)
        begin
          st_nxt.unit_cnt = st_r.unit_cnt + 1'b1;
        end
        else if (st_r.hold_left > seq_pkg::HOLD_MIN_UNITS)
        begin
          st_nxt.unit_cnt = '0;
          st_nxt.hold_left = st_r.hold_left - 1'b1;
        end
        else if (!step_last)
        begin
          st_nxt.idx = st_r.dir_down ? idx_add(st_r.idx, '1) :
            idx_add(st_r.idx, seq_pkg::IDX_W'(1));
          st_nxt.run = seq_pkg::RUN_LOAD;
        end
        else if (st_r.pass + 1'b1 >= st_r.repeat_total)
        begin
          st_nxt.run = seq_pkg::RUN_IDLE;
        end
        else if (st_r.dir_down)
        begin
          st_nxt.pass = st_r.pass + 1'b1;
          st_nxt.idx = idx_add(st_r.len, '1);
          st_nxt.run = seq_pkg::RUN_LOAD;
        end
        else if (seq_pkg::IDX_W'(st_r.lead_step_omit) < st_r.len)
        begin
          st_nxt.pass = st_r.pass + 1'b1;
          st_nxt.idx = seq_pkg::IDX_W'(st_r.lead_step_omit);
          st_nxt.run = seq_pkg::RUN_LOAD;
        end
        else
        begin
          st_nxt.run = seq_pkg::RUN_IDLE;
        end
      end
      default:
      begin
        st_nxt.run = seq_pkg::RUN_IDLE;
      end
    endcase
    if (go)
    begin
      case (op)
        seq_pkg::OP_OUT_OFF:
        begin
          st_nxt.out_on = 1'b0;
        end
        seq_pkg::OP_OUT_ON:
        begin
          st_nxt.out_on = 1'b1;
        end
        seq_pkg::OP_REMOTE:
        begin
          st_nxt.remote = 1'b1;
          st_nxt.out_on = 1'b0;
        end
        seq_pkg::OP_LOCAL:
        begin
          st_nxt.remote = 1'b0;
          st_nxt.out_on = 1'b1;
        end
        seq_pkg::OP_SET_VOLT:
        begin
          st_nxt.vset = st_r.arg;
        end
        seq_pkg::OP_SET_CURR:
        begin
          st_nxt.iset = st_r.arg;
        end
        seq_pkg::OP_REG_VOLT, seq_pkg::OP_REG_CURR:
        begin
          st_nxt.reg_mode = (op == seq_pkg::OP_REG_CURR);
          st_nxt.run = seq_pkg::RUN_IDLE;
        end
        seq_pkg::OP_STYLE_FIXED, seq_pkg::OP_STYLE_TRAN:
        begin
          st_nxt.run = seq_pkg::RUN_IDLE;
        end
        seq_pkg::OP_TRIG_VOLT, seq_pkg::OP_TRIG_CURR:
        begin
          st_nxt.trig_mode = (op == seq_pkg::OP_TRIG_CURR);
        end
        seq_pkg::OP_TRIGGER:
        begin
          st_nxt.reg_mode = st_r.trig_mode;
        end
        seq_pkg::OP_SETUP_SAVE:
        begin
          st_nxt.saved_trig = st_r.trig_mode;
        end
        seq_pkg::OP_SETUP_RECALL:
        begin
          st_nxt.trig_mode = st_r.saved_trig;
        end
        seq_pkg::OP_LIST_CLEAR:
        begin
          st_nxt.cfill = '0;
          st_nxt.vfill = '0;
          st_nxt.hfill = '0;
          st_nxt.qptr = '0;
          st_nxt.dir_down = 1'b0;
          st_nxt.order_custom = 1'b0;
          st_nxt.repeat_total = seq_pkg::REPEAT_CLEAR;
          st_nxt.lead_step_omit = seq_pkg::OMIT_CLEAR;
          st_nxt.run = seq_pkg::RUN_IDLE;
        end
        seq_pkg::OP_SET_REPEAT:
        begin
          st_nxt.repeat_total = st_r.arg[seq_pkg::CNT_W-1:0];
        end
        seq_pkg::OP_SET_OMIT:
        begin
          st_nxt.lead_step_omit = st_r.arg[seq_pkg::CNT_W-1:0];
        end
        seq_pkg::OP_CURR_APPEND:
        begin
          if (st_r.vfill != '0)
          begin
            st_nxt.conflict = 1'b1;
            st_nxt.err_code = seq_pkg::ERR_SETTINGS_CONFLICT;
          end
          else if (st_r.cfill < DEPTH_IDX)
          begin
            tbl_we = 1'b1;
            st_nxt.cfill = idx_add(st_r.cfill, seq_pkg::IDX_W'(1));
          end
        end
        seq_pkg::OP_VOLT_APPEND:
        begin
          if (st_r.vfill < DEPTH_IDX)
          begin
            tbl_we = 1'b1;
            tbl_widx = st_r.vfill;
            st_nxt.vfill = idx_add(st_r.vfill, seq_pkg::IDX_W'(1));
          end
        end
        seq_pkg::OP_HOLD_APPEND:
        begin
          if (st_r.hfill < DEPTH_IDX)
          begin
            hold_we = 1'b1;
            st_nxt.hfill = idx_add(st_r.hfill, seq_pkg::IDX_W'(1));
          end
        end
        seq_pkg::OP_SET_DIR:
        begin
          st_nxt.dir_down = st_r.arg[0];
        end
        seq_pkg::OP_SET_ORDER:
        begin
          st_nxt.order_custom = st_r.arg[0];
        end
        seq_pkg::OP_SET_QPTR:
        begin
          st_nxt.qptr = st_r.arg[seq_pkg::IDX_W-1:0];
        end
        seq_pkg::OP_RUN_LIST:
        begin
          st_nxt.len = st_r.reg_mode ? st_r.cfill : st_r.vfill;
          if (st_nxt.len != '0 && st_r.repeat_total != '0)
          begin
            st_nxt.pass = '0;
            st_nxt.idx = st_r.dir_down ? idx_add(st_nxt.len, '1) : '0;
            st_nxt.run = seq_pkg::RUN_LOAD;
          end
        end
        seq_pkg::OP_Q_OUT, seq_pkg::OP_Q_REG, seq_pkg::OP_Q_TRIG,
        seq_pkg::OP_Q_REPEAT, seq_pkg::OP_Q_OMIT, seq_pkg::OP_Q_VOLT,
        seq_pkg::OP_Q_CURR:
        begin
          st_nxt.result_new = 1'b1;
          case (op)
            seq_pkg::OP_Q_OUT: st_nxt.result = seq_pkg::DATA_W'(st_r.out_on);
            seq_pkg::OP_Q_REG: st_nxt.result = seq_pkg::DATA_W'(st_r.reg_mode);
            seq_pkg::OP_Q_TRIG: st_nxt.result = seq_pkg::DATA_W'(st_r.trig_mode);
            seq_pkg::OP_Q_REPEAT: st_nxt.result = seq_pkg::DATA_W'(st_r.repeat_total);
            seq_pkg::OP_Q_OMIT: st_nxt.result = seq_pkg::DATA_W'(st_r.lead_step_omit);
            seq_pkg::OP_Q_VOLT: st_nxt.result = st_r.vset;
            default: st_nxt.result = st_r.iset;
          endcase
        end
        seq_pkg::OP_Q_READBACK, seq_pkg::OP_Q_FILL:
        begin
          if (st_r.vfill != '0)
          begin
            st_nxt.conflict = 1'b1;
            st_nxt.err_code = seq_pkg::ERR_SETTINGS_CONFLICT;
          end
          else if (op == seq_pkg::OP_Q_FILL)
          begin
            st_nxt.result = seq_pkg::DATA_W'(st_r.cfill);
            st_nxt.result_new = 1'b1;
          end
          else
          begin
            st_nxt.result = (rb_idx < st_r.cfill) ? rb_val : '0;
            st_nxt.result_new = 1'b1;
          end
        end
        default:
        begin
          st_nxt.result_new = st_nxt.result_new;
        end
      endcase
    end
    st_nxt.prog.volt = st_nxt.out_on ? st_nxt.vset : '0;
    st_nxt.prog.curr = st_nxt.out_on ? st_nxt.iset : '0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.out_on <= 1'b1;
      st_r.repeat_total <= seq_pkg::REPEAT_CLEAR;
      st_r.run <= seq_pkg::RUN_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  always_comb
  begin
    apb_out.pready = 1'b1;
    apb_out.pslverr = 1'b0;
    apb_out.prdata = '0;
    case (apb_in.paddr)
      seq_pkg::OFS_CMD:
      begin
        apb_out.prdata = '0;
      end
      seq_pkg::OFS_ARG:
      begin
        apb_out.prdata = st_r.arg;
      end
      seq_pkg::OFS_RESULT:
      begin
        apb_out.prdata = st_r.result;
      end
      seq_pkg::OFS_STATUS:
      begin
        apb_out.prdata[seq_pkg::ST_OUT_ON] = st_r.out_on;
        apb_out.prdata[seq_pkg::ST_REG_MODE] = st_r.reg_mode;
        apb_out.prdata[seq_pkg::ST_TRIG_MODE] = st_r.trig_mode;
        apb_out.prdata[seq_pkg::ST_RUNNING] = (st_r.run != seq_pkg::RUN_IDLE);
        apb_out.prdata[seq_pkg::ST_REMOTE] = st_r.remote;
        apb_out.prdata[seq_pkg::ST_DIR_DOWN] = st_r.dir_down;
        apb_out.prdata[seq_pkg::ST_ORDER] = st_r.order_custom;
        apb_out.prdata[seq_pkg::ST_LIMIT_ERR] = st_r.limit_err;
        apb_out.prdata[seq_pkg::ST_CONFLICT] = st_r.conflict;
        apb_out.prdata[seq_pkg::ST_RESULT_NEW] = st_r.result_new;
      end
      seq_pkg::OFS_ERROR:
      begin
        apb_out.prdata = st_r.conflict ? seq_pkg::DATA_W'(st_r.err_code) : '0;
      end
      seq_pkg::OFS_FILL:
      begin
        apb_out.prdata[seq_pkg::IDX_W-1:0] = st_r.cfill;
        apb_out.prdata[seq_pkg::FILL_V_LSB +: seq_pkg::IDX_W] = st_r.vfill;
      end
      default:
      begin
        apb_out.pslverr = apb_in.psel && apb_in.penable;
      end
    endcase
  end

  assign prog = st_r.prog;
  assign out_enabled = st_r.out_on;
  assign panel_active = !st_r.remote;
  assign regulation_current = st_r.reg_mode;
  assign list_running = (st_r.run != seq_pkg::RUN_IDLE);
endmodule
`default_nettype wire

// file: testbench/seq_properties.sv
// Port-level assertions of the output and list sequencer
`timescale 1ns/10ps
`default_nettype none
module seq_properties #(
  parameter int HOLD_UNIT_CYC = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire seq_pkg::apb_req_t apb_in,
  input wire seq_pkg::apb_rsp_t apb_out,
  input wire logic cur_limit_pin,
  input wire logic volt_limit_pin,
  input wire seq_pkg::prog_out_t prog,
  input wire logic out_enabled,
  input wire logic panel_active,
  input wire logic regulation_current,
  input wire logic list_running
);
  logic cmd;
  logic [7:0] op;
  assign cmd = apb_in.psel && apb_in.penable && apb_in.pwrite && apb_in.paddr == 12'h000;
  assign op = apb_in.pwdata[7:0];
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_off_zeroes: assert property (!out_enabled |-> prog == '0)
    else $error("setpoints not zero while off");
  a_on_enables: assert property (cmd && op == 8'h02 |=> out_enabled)
    else $error("output not enabled");
  a_remote_off: assert property (cmd && op == 8'h03 |=> !out_enabled && !panel_active)
    else $error("remote entry left output on");
  a_local_on: assert property (cmd && op == 8'h04 |=> out_enabled && panel_active)
    else $error("local entry left output off");
  a_mode_curr: assert property (cmd && op == 8'h08 |=> regulation_current)
    else $error("current mode not held");
  a_mode_stops: assert property (cmd && op inside {8'h07, 8'h08, 8'h18, 8'h19}
    |=> !list_running)
    else $error("list kept running");
  a_clear_stops: assert property (cmd && op == 8'h0E |=> !list_running)
    else $error("clear left list running");
  a_step_hold: assert property (list_running && $changed(prog) |=> $stable(prog)[*3])
    else $error("step left before hold ended");
  a_err_access: assert property (apb_out.pslverr |-> apb_in.psel && apb_in.penable)
    else $error("error outside access phase");
  c_run: cover property (cmd && op == 8'h17);
  c_done: cover property ($fell(list_running));
  c_slverr: cover property (apb_out.pslverr);
endmodule
bind output_and_list_sequencer seq_properties #(.HOLD_UNIT_CYC(HOLD_UNIT_CYC)) u_props (
  .pclk(pclk), .presetn(presetn), .apb_in(apb_in), .apb_out(apb_out),
  .cur_limit_pin(cur_limit_pin), .volt_limit_pin(volt_limit_pin), .prog(prog),
  .out_enabled(out_enabled), .panel_active(panel_active),
  .regulation_current(regulation_current), .list_running(list_running)
);
`default_nettype wire

// file: testbench/host_model.sv
// Remote host sending parsed commands over APB
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic pclk,
  input wire seq_pkg::apb_rsp_t rsp,
  output seq_pkg::apb_req_t req,
  output logic hung
);
  initial req = '0;
  initial hung = 1'b0;
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd);
    int n;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 64);
    if (rsp.pready !== 1'b1)
      hung <= 1'b1;
    rd = rsp.prdata;
    req <= '0;
  endtask
  task automatic cmd(input seq_pkg::op_t op, input logic [31:0] arg);
    logic [31:0] rd;
    xfer(1'b1, seq_pkg::OFS_ARG, arg, rd);
    xfer(1'b1, seq_pkg::OFS_CMD, {24'h000000, op}, rd);
  endtask
endmodule
`default_nettype wire

// file: testbench/test_output_and_list_sequencer.sv
// Self-checking bench of the output and list sequencer
`timescale 1ns/10ps
`default_nettype none
module test_output_and_list_sequencer;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic cl = 1'b0;
  logic vl = 1'b0;
  logic oe, pa, rc, lr, hung;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] expq[$];
  logic [31:0] q;
  logic [31:0] v[3];
  seq_pkg::apb_req_t req;
  seq_pkg::apb_rsp_t rsp;
  seq_pkg::prog_out_t prog;
  initial forever #12.5 pclk = ~pclk;
  host_model host (.pclk(pclk), .rsp(rsp), .req(req), .hung(hung));
  output_and_list_sequencer #(.HOLD_UNIT_CYC(4)) dut (.pclk(pclk), .presetn(presetn),
    .apb_in(req), .apb_out(rsp), .cur_limit_pin(cl), .volt_limit_pin(vl), .prog(prog),
    .out_enabled(oe), .panel_active(pa), .regulation_current(rc), .list_running(lr));
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic ask(input seq_pkg::op_t op, input logic [31:0] arg, input logic [31:0] exp);
    expq.push_back(exp);
    host.cmd(op, arg);
    host.xfer(1'b0, seq_pkg::OFS_RESULT, '0, q);
  endtask
  task automatic run(input int steps, input logic [31:0] last);
    int n;
    host.cmd(seq_pkg::OP_RUN_LIST, '0);
    n = 0;
    @(negedge pclk);
    while (lr === 1'b1 && n < 400)
    begin
      @(negedge pclk);
      n++;
    end
    check("run_len", n, steps);
    check("last_step", prog.curr, last);
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (req.psel && req.penable && !req.pwrite && req.paddr == seq_pkg::OFS_RESULT)
      check("result", rsp.prdata, expq.pop_front());
    if (hung || cyc > 50000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(28575));
    foreach (v[i]) v[i] = $urandom;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("local_on", {pa, oe}, 2'h3);
    ask(seq_pkg::OP_Q_OUT, '0, 1'h1);
    host.cmd(seq_pkg::OP_REMOTE, '0);
    @(negedge pclk);
    check("remote_off", oe, 1'h0);
    host.cmd(seq_pkg::OP_OUT_ON, '0);
    host.cmd(seq_pkg::OP_SET_VOLT, v[0]);
    host.cmd(seq_pkg::OP_SET_CURR, v[1]);
    host.cmd(seq_pkg::OP_OUT_OFF, '0);
    @(negedge pclk);
    check("off_volt", prog.volt, '0);
    ask(seq_pkg::OP_Q_OUT, '0, '0);
    ask(seq_pkg::OP_Q_VOLT, '0, v[0]);
    ask(seq_pkg::OP_Q_CURR, '0, v[1]);
    host.cmd(seq_pkg::OP_OUT_ON, '0);
    @(negedge pclk);
    check("on_curr", prog.curr, v[1]);
    host.cmd(seq_pkg::OP_TRIG_CURR, '0);
    host.cmd(seq_pkg::OP_TRIGGER, '0);
    ask(seq_pkg::OP_Q_REG, '0, 1'h1);
    check("reg_pin", rc, 1'h1);
    host.cmd(seq_pkg::OP_SETUP_SAVE, '0);
    host.cmd(seq_pkg::OP_TRIG_VOLT, '0);
    ask(seq_pkg::OP_Q_TRIG, '0, '0);
    host.cmd(seq_pkg::OP_SETUP_RECALL, '0);
    ask(seq_pkg::OP_Q_TRIG, '0, 1'h1);
    host.cmd(seq_pkg::OP_REG_VOLT, '0);
    ask(seq_pkg::OP_Q_REG, '0, '0);
    vl <= 1'b1;
    repeat (10) @(posedge pclk);
    host.xfer(1'b0, seq_pkg::OFS_STATUS, '0, q);
    check("limit_v", q[7], 1'h0);
    cl <= 1'b1;
    repeat (10) @(posedge pclk);
    host.xfer(1'b0, seq_pkg::OFS_STATUS, '0, q);
    check("limit_c", q[7], 1'h1);
    host.cmd(seq_pkg::OP_LIST_CLEAR, '0);
    ask(seq_pkg::OP_Q_REPEAT, '0, 1'h1);
    ask(seq_pkg::OP_Q_OMIT, '0, '0);
    host.cmd(seq_pkg::OP_REG_CURR, '0);
    foreach (v[i]) host.cmd(seq_pkg::OP_CURR_APPEND, v[i]);
    ask(seq_pkg::OP_Q_FILL, '0, 32'h3);
    host.cmd(seq_pkg::OP_SET_QPTR, '0);
    ask(seq_pkg::OP_Q_READBACK, 32'h2, v[2]);
    host.cmd(seq_pkg::OP_SET_REPEAT, 32'h2);
    host.cmd(seq_pkg::OP_SET_OMIT, 32'h1);
    ask(seq_pkg::OP_Q_REPEAT, '0, 32'h2);
    host.cmd(seq_pkg::OP_HOLD_APPEND, 32'h2);
    run(45, v[2]);
    host.cmd(seq_pkg::OP_SET_DIR, 32'h1);
    run(54, v[0]);
    host.cmd(seq_pkg::OP_RUN_LIST, '0);
    host.cmd(seq_pkg::OP_REG_CURR, '0);
    @(negedge pclk);
    check("stopped", lr, 1'h0);
    host.cmd(seq_pkg::OP_RUN_LIST, '0);
    @(negedge pclk);
    check("started", lr, 1'h1);
    host.cmd(seq_pkg::OP_STYLE_TRAN, '0);
    @(negedge pclk);
    check("style_stop", lr, 1'h0);
    host.cmd(seq_pkg::OP_LIST_CLEAR, '0);
    host.cmd(seq_pkg::OP_REG_VOLT, '0);
    host.cmd(seq_pkg::OP_VOLT_APPEND, v[0]);
    host.cmd(seq_pkg::OP_REG_CURR, '0);
    host.cmd(seq_pkg::OP_CURR_APPEND, v[1]);
    host.xfer(1'b0, seq_pkg::OFS_ERROR, '0, q);
    check("conflict", q, 32'h0000FF23);
    host.xfer(1'b0, 12'h020, '0, q);
    check("unmapped", q, '0);
    host.cmd(seq_pkg::OP_LOCAL, '0);
    @(negedge pclk);
    check("local_back", {pa, oe}, 2'h3);
    end_sim();
  end
endmodule
`default_nettype wire
